// file: hw/afe_power_hpf_pkg.sv
// Constants and types for the front end power-level and filter-switch registers.
// Assumes an APB slave with 32-bit data; register indices are scaled by four.
package afe_power_hpf_pkg;

  localparam int unsigned REG_W         = 16;
  localparam int unsigned CHANNELS      = 16;
  localparam int unsigned GROUPS        = 4;
  localparam int unsigned ADDR_W        = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] LOW_POWER_IDX   = 8'hc8;
  localparam logic [7:0] MID_POWER_IDX   = 8'hce;
  localparam logic [7:0] FILTER_SW_IDX   = 8'he6;
  localparam logic [7:0] STATUS_IDX      = 8'hf0;

  localparam logic [ADDR_W-1:0] LOW_POWER_ADDR = {2'h0, LOW_POWER_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] MID_POWER_ADDR = {2'h0, MID_POWER_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] FILTER_SW_ADDR = {2'h0, FILTER_SW_IDX, 2'h0};
  localparam logic [ADDR_W-1:0] STATUS_ADDR    = {2'h0, STATUS_IDX, 2'h0};

  // Field positions
  localparam int unsigned REDUCED_POWER_BIT = 12;
  localparam int unsigned MID_POWER_BIT     = 14;
  localparam int unsigned SOURCE_BIT        = 4;
  localparam int unsigned GROUP_LSB         = 0;

  // Values after reset
  localparam logic [REG_W-1:0] LOW_POWER_RESET = 16'h0000;
  localparam logic [REG_W-1:0] MID_POWER_RESET = 16'h0000;
  localparam logic [REG_W-1:0] FILTER_SW_RESET = 16'h0000;

  typedef enum logic [1:0] {
    POWER_DEFAULT,
    POWER_MEDIUM,
    POWER_LOW
  } power_level_t;

  // Block state as software sees it in the status word
  typedef struct packed {
    logic [CHANNELS-1:0] filter_connect;
    logic [11:0]         spare;
    logic                cw_mode;
    logic                hpf_powered;
    power_level_t        power_level;
  } status_word_t;

endpackage

// file: hw/afe_power_hpf_regs.sv
// APB register bank selecting amplifier power level and input filter switching.
// Assumes mode and receive-switch pins are asynchronous; all else on pclk.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module afe_power_hpf_regs #(
  parameter int unsigned CHANNELS = 16,
  parameter int unsigned GROUPS   = 4
) (
  input  wire logic                                     pclk,
  input  wire logic                                     presetn,
  input  wire logic                                     psel,
  input  wire logic                                     penable,
  input  wire logic                                     pwrite,
  input  wire logic [afe_power_hpf_pkg::ADDR_W-1:0]     paddr,
  input  wire logic [31:0]                              pwdata,
  output var  logic [31:0]                              prdata,
  output var  logic                                     pready,
  output var  logic                                     pslverr,
  input  wire logic                                     continuous_wave_mode,
  input  wire logic [CHANNELS-1:0]                      receive_switch_pin,
  output var  afe_power_hpf_pkg::power_level_t          power_level,
  output var  logic [CHANNELS-1:0]                      filter_connect,
  output var  logic                                     hpf_powered
);

  // Group decode assumes four groups of four; other counts cannot be served
  if (CHANNELS != afe_power_hpf_pkg::CHANNELS ||
      GROUPS != afe_power_hpf_pkg::GROUPS) begin : g_bad_counts
    $error("Channel and group counts must match the register layout");
  end

  localparam int unsigned PER_GROUP = CHANNELS / GROUPS;

  logic [afe_power_hpf_pkg::REG_W-1:0] low_power_reg;
  logic [afe_power_hpf_pkg::REG_W-1:0] mid_power_reg;
  logic [afe_power_hpf_pkg::REG_W-1:0] filter_sw_reg;
  logic                                cw_meta_reg;
  logic                                cw_sync_reg;
  logic [CHANNELS-1:0]                 pin_meta_reg;
  logic [CHANNELS-1:0]                 pin_sync_reg;
  logic [31:0]                         prdata_reg;
  logic                                pready_reg;
  logic                                pslverr_reg;
  afe_power_hpf_pkg::power_level_t     power_level_reg;
  afe_power_hpf_pkg::power_level_t     power_level_next;
  logic [CHANNELS-1:0]                 filter_connect_reg;
  logic [CHANNELS-1:0]                 filter_connect_next;
  logic                                hpf_powered_reg;

  // Bus decode
  wire logic access_first = psel && penable && !pready_reg;
  wire logic access_done  = psel && penable && pready_reg;
  wire logic hit_low      = (paddr == afe_power_hpf_pkg::LOW_POWER_ADDR);
  wire logic hit_mid      = (paddr == afe_power_hpf_pkg::MID_POWER_ADDR);
  wire logic hit_filter   = (paddr == afe_power_hpf_pkg::FILTER_SW_ADDR);
  wire logic hit_status   = (paddr == afe_power_hpf_pkg::STATUS_ADDR);
  wire logic hit_any      = hit_low || hit_mid || hit_filter || hit_status;
  wire logic do_write     = access_done && pwrite && !pslverr_reg;
  wire logic [15:0] wdata = pwdata[15:0];

  // Decoded controls
  wire logic reduced_power_sel    = low_power_reg[afe_power_hpf_pkg::REDUCED_POWER_BIT];
  wire logic mid_power_sel        = mid_power_reg[afe_power_hpf_pkg::MID_POWER_BIT];
  wire logic filter_switch_source = filter_sw_reg[afe_power_hpf_pkg::SOURCE_BIT];
  wire logic [GROUPS-1:0] group_filter_connect =
    filter_sw_reg[afe_power_hpf_pkg::GROUP_LSB +: GROUPS];

  afe_power_hpf_pkg::status_word_t status_word;
  assign status_word.filter_connect = filter_connect_reg;
  assign status_word.spare          = 12'h000;
  assign status_word.cw_mode        = cw_sync_reg;
  assign status_word.hpf_powered    = hpf_powered_reg;
  assign status_word.power_level    = power_level_reg;

  wire logic [31:0] read_value =
    hit_low    ? {16'h0000, low_power_reg} :
    hit_mid    ? {16'h0000, mid_power_reg} :
    hit_filter ? {16'h0000, filter_sw_reg} :
    hit_status ? status_word : 32'h0000_0000;

  // Power level: continuous-wave mode ignores both selections, low beats medium
  assign power_level_next =
    cw_sync_reg       ? afe_power_hpf_pkg::POWER_DEFAULT :
    reduced_power_sel ? afe_power_hpf_pkg::POWER_LOW :
    mid_power_sel     ? afe_power_hpf_pkg::POWER_MEDIUM :
                        afe_power_hpf_pkg::POWER_DEFAULT;

  // Under pin control, pin high means the channel is in its protect phase and the filter is detached
  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_channel
      assign filter_connect_next[ch] = filter_switch_source ?
        group_filter_connect[ch / PER_GROUP] :
        !pin_sync_reg[ch];
    end
  endgenerate

  // Pins cross from outside the clock domain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cw_meta_reg  <= 1'b0;
      cw_sync_reg  <= 1'b0;
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      cw_meta_reg  <= continuous_wave_mode;
      cw_sync_reg  <= cw_meta_reg;
      pin_meta_reg <= receive_switch_pin;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Unused bits are stored as written; software keeps them zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_power_reg <= afe_power_hpf_pkg::LOW_POWER_RESET;
      mid_power_reg <= afe_power_hpf_pkg::MID_POWER_RESET;
      filter_sw_reg <= afe_power_hpf_pkg::FILTER_SW_RESET;
    end else if (do_write) begin
      if (hit_low) begin
        low_power_reg <= wdata;
      end else if (hit_mid) begin
        mid_power_reg <= wdata;
      end else if (hit_filter) begin
        filter_sw_reg <= wdata;
      end
    end
  end

  // Two-cycle access: answer is prepared in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
    end else begin
      pready_reg  <= access_first;
      pslverr_reg <= access_first && (!hit_any || (pwrite && hit_status));
      prdata_reg  <= (access_first && !pwrite) ? read_value : 32'h0000_0000;
    end
  end

  // Filter stays powered whatever its link state, so overload recovery is fast
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_level_reg    <= afe_power_hpf_pkg::POWER_DEFAULT;
      filter_connect_reg <= '0;
      hpf_powered_reg    <= 1'b0;
    end else begin
      power_level_reg    <= power_level_next;
      filter_connect_reg <= filter_connect_next;
      hpf_powered_reg    <= 1'b1;
    end
  end

  assign prdata         = prdata_reg;
  assign pready         = pready_reg;
  assign pslverr        = pslverr_reg;
  assign power_level    = power_level_reg;
  assign filter_connect = filter_connect_reg;
  assign hpf_powered    = hpf_powered_reg;

  a_low_power_take: assert property (@(posedge pclk) disable iff (!presetn)
    (reduced_power_sel && !cw_sync_reg) |=> (power_level_reg == afe_power_hpf_pkg::POWER_LOW))
    else $error("Low power not applied");

  a_default_level: assert property (@(posedge pclk) disable iff (!presetn)
    (!reduced_power_sel && !mid_power_sel) |=>
      (power_level_reg == afe_power_hpf_pkg::POWER_DEFAULT))
    else $error("Level left default without selection");

  a_cw_ignores_low: assert property (@(posedge pclk) disable iff (!presetn)
    (cw_sync_reg && reduced_power_sel) |=>
      (power_level_reg == afe_power_hpf_pkg::POWER_DEFAULT))
    else $error("Low power applied in continuous-wave mode");

  a_mid_power_take: assert property (@(posedge pclk) disable iff (!presetn)
    (mid_power_sel && !reduced_power_sel && !cw_sync_reg) |=>
      (power_level_reg == afe_power_hpf_pkg::POWER_MEDIUM))
    else $error("Medium power not applied");

  a_low_wins_mid: assert property (@(posedge pclk) disable iff (!presetn)
    (mid_power_sel && reduced_power_sel && !cw_sync_reg) |=>
      (power_level_reg == afe_power_hpf_pkg::POWER_LOW))
    else $error("Medium power overrode low power");

  a_cw_ignores_mid: assert property (@(posedge pclk) disable iff (!presetn)
    cw_sync_reg |=> (power_level_reg != afe_power_hpf_pkg::POWER_MEDIUM))
    else $error("Medium power applied in continuous-wave mode");

  a_pin_source: assert property (@(posedge pclk) disable iff (!presetn)
    !filter_switch_source |=> (filter_connect_reg == ~$past(pin_sync_reg)))
    else $error("Filter link does not follow switch pins");

  a_group_source: assert property (@(posedge pclk) disable iff (!presetn)
    filter_switch_source |=>
      (filter_connect_reg == {{4{$past(filter_sw_reg[3])}}, {4{$past(filter_sw_reg[2])}},
                              {4{$past(filter_sw_reg[1])}}, {4{$past(filter_sw_reg[0])}}}))
    else $error("Filter link does not follow group bits");

  a_group_detach: assert property (@(posedge pclk) disable iff (!presetn)
    (filter_switch_source && !filter_sw_reg[0]) |=> (filter_connect_reg[3:0] == 4'h0))
    else $error("Group one filter not detached");

  a_filter_powered: assert property (@(posedge pclk) disable iff (!presetn)
    $past(hpf_powered_reg) |-> hpf_powered_reg)
    else $error("Filter powered down");

  a_write_stores: assert property (@(posedge pclk) disable iff (!presetn)
    (do_write && hit_mid) |=> (mid_power_reg == $past(pwdata[15:0])))
    else $error("Write to mid-power register lost");

  a_ready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready_reg) |=> pready_reg ##1 !pready_reg)
    else $error("Ready not a single-cycle answer");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (access_first && !hit_any) |=>
      (pslverr_reg && pready_reg && (prdata_reg == 32'h0000_0000)))
    else $error("Unmapped access not refused");

  a_status_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_first && pwrite && hit_status) |=>
      (pslverr_reg && pready_reg))
    else $error("Write to status not refused");

  a_error_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
    pslverr_reg |->
      pready_reg)
    else $error("Error flag without ready");

  a_idle_no_ready: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable) |=>
      !pready_reg)
    else $error("Ready raised outside an access");

  a_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !pready_reg |->
      (prdata_reg == 32'h0000_0000))
    else $error("Read data not zero outside an answer");

  a_read_low: assert property (@(posedge pclk) disable iff (!presetn)
    (access_first && !pwrite && hit_low) |=>
      (prdata_reg == {16'h0000, $past(low_power_reg)}))
    else $error("Low-power register read wrong");

  a_read_mid: assert property (@(posedge pclk) disable iff (!presetn)
    (access_first && !pwrite && hit_mid) |=>
      (prdata_reg == {16'h0000, $past(mid_power_reg)}))
    else $error("Mid-power register read wrong");

  a_read_filter: assert property (@(posedge pclk) disable iff (!presetn)
    (access_first && !pwrite && hit_filter) |=>
      (prdata_reg == {16'h0000, $past(filter_sw_reg)}))
    else $error("Filter switch register read wrong");

  a_read_status: assert property (@(posedge pclk) disable iff (!presetn)
    (access_first && !pwrite && hit_status) |=>
      (prdata_reg == $past(status_word)))
    else $error("Status read wrong");

  a_write_low_stores: assert property (@(posedge pclk) disable iff (!presetn)
    (do_write && hit_low) |=>
      (low_power_reg == $past(pwdata[15:0])))
    else $error("Write to low-power register lost");

  a_write_filter_stores: assert property (@(posedge pclk) disable iff (!presetn)
    (do_write && hit_filter) |=>
      (filter_sw_reg == $past(pwdata[15:0])))
    else $error("Write to filter switch register lost");

  a_error_no_write: assert property (@(posedge pclk) disable iff (!presetn)
    (access_done && pwrite && pslverr_reg) |=>
      ($stable(low_power_reg) && $stable(mid_power_reg) && $stable(filter_sw_reg)))
    else $error("Refused write changed a register");

  a_cw_default: assert property (@(posedge pclk) disable iff (!presetn)
    cw_sync_reg |=>
      (power_level_reg == afe_power_hpf_pkg::POWER_DEFAULT))
    else $error("Power level not default in continuous-wave mode");

  a_pins_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (filter_switch_source && $stable(filter_sw_reg)) |=>
      $stable(filter_connect_reg))
    else $error("Switch pins moved the filter link under register control");

  a_detach_powered: assert property (@(posedge pclk) disable iff (!presetn)
    (filter_switch_source && (group_filter_connect == '0)) |=>
      ((filter_connect_reg == '0) && hpf_powered_reg))
    else $error("Detached filter lost power or stayed attached");

endmodule

`default_nettype wire

// file: verification/apb_host_model.sv
// Host controller model: APB master issuing one transfer per call.
// Assumes the slave raises pready within a bounded number of cycles.
`timescale 1ns/1ps
`default_nettype none

module apb_host_model (
  input  wire logic        pclk,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0;
  end

  // Callers pass only named fields set, unnamed bits zero
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output bit to);
    to = 1'b1;
    q = 32'h0;
    e = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Request held until pready is seen high at an edge
    for (int n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) begin
        q = prdata;
        e = pslverr;
        to = 1'b0;
        break;
      end
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

`default_nettype wire

// file: verification/tb.sv
// Self-checking bench for the power-level and filter-switch register bank.
// Assumes the host model drives APB; pins and mode are driven here.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        cw = 1'b0;
  logic [15:0] pins = 16'h0;
  logic        psel, penable, pwrite, pready, pslverr, hpf_powered;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] filter_connect;
  afe_power_hpf_pkg::power_level_t power_level;
  int          num_errors = 0;
  int          n_checks = 0;
  int          seed = 32'h7cc8958e;

  always #2.5 pclk = ~pclk;

  afe_power_hpf_regs i_afe_power_hpf_regs (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .continuous_wave_mode(cw),
    .receive_switch_pin(pins), .power_level(power_level),
    .filter_connect(filter_connect), .hpf_powered(hpf_powered));

  apb_host_model i_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; error flag compared on every access, read data on reads only
  task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] q_exp, input logic e_exp);
    logic [31:0] q;
    logic        e;
    bit          to;
    i_host.xfer(w, a, d, q, e, to);
    if (to) begin
      num_errors++;
      $display("unexpected at %0t: no pready", $time);
      tally_and_finish();
    end
    chk(e, e_exp, "pslverr");
    if (!w) chk(q, q_exp, "read data");
  endtask

  // Continuous-wave mode ignores both power bits; reduced power wins over mid
  function automatic afe_power_hpf_pkg::power_level_t lvl(logic lo, logic md, logic c);
    if (c || (!lo && !md)) return afe_power_hpf_pkg::POWER_DEFAULT;
    return lo ? afe_power_hpf_pkg::POWER_LOW : afe_power_hpf_pkg::POWER_MEDIUM;
  endfunction

  // Group g covers channels 4g..4g+3; a high pin detaches under pin control
  function automatic logic [15:0] conn(logic [4:0] f, logic [15:0] p);
    logic [15:0] r;
    for (int c = 0; c < 16; c++) r[c] = f[4] ? f[c/4] : !p[c];
    return r;
  endfunction

  initial begin
    logic [31:0] d;
    logic        lo, md;
    logic [4:0]  f;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(hpf_powered, 32'h1, "powered after reset");
    chk(filter_connect, 32'hffff, "pin control after reset");
    chk(power_level, 32'h0, "default level");
    acc(1'b0, afe_power_hpf_pkg::LOW_POWER_ADDR, 32'h0, 32'h0, 1'b0);
    acc(1'b0, afe_power_hpf_pkg::MID_POWER_ADDR, 32'h0, 32'h0, 1'b0);
    acc(1'b0, afe_power_hpf_pkg::FILTER_SW_ADDR, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 12'h004, 32'h0, 32'h0, 1'b1);
    acc(1'b1, afe_power_hpf_pkg::STATUS_ADDR, 32'h1, 32'h0, 1'b1);
    acc(1'b1, 12'h004, 32'h1, 32'h0, 1'b1);
    // First eight passes walk every power and mode combination
    for (int i = 0; i < 24; i++) begin
      d = $random(seed);
      lo = (i < 8) ? i[0] : d[0];
      md = (i < 8) ? i[1] : d[1];
      f = (i < 4) ? {1'b1, 4'h1 << i} : d[8:4];
      pins <= d[31:16];
      cw <= (i < 8) ? i[2] : d[2];
      acc(1'b1, afe_power_hpf_pkg::LOW_POWER_ADDR, {19'h0, lo, 12'h0}, 32'h0, 1'b0);
      acc(1'b1, afe_power_hpf_pkg::MID_POWER_ADDR, {17'h0, md, 14'h0}, 32'h0, 1'b0);
      acc(1'b1, afe_power_hpf_pkg::FILTER_SW_ADDR, {27'h0, f}, 32'h0, 1'b0);
      acc(1'b0, afe_power_hpf_pkg::LOW_POWER_ADDR, 32'h0, {19'h0, lo, 12'h0}, 1'b0);
      acc(1'b0, afe_power_hpf_pkg::MID_POWER_ADDR, 32'h0, {17'h0, md, 14'h0}, 1'b0);
      acc(1'b0, afe_power_hpf_pkg::FILTER_SW_ADDR, 32'h0, {27'h0, f}, 1'b0);
      repeat (4) @(posedge pclk);
      chk(power_level, lvl(lo, md, cw), "power level");
      chk(filter_connect, conn(f, pins), "filter link");
      chk(hpf_powered, 32'h1, "filter powered");
      acc(1'b0, afe_power_hpf_pkg::STATUS_ADDR, 32'h0,
          {conn(f, pins), 12'h000, cw, 1'b1, lvl(lo, md, cw)}, 1'b0);
    end
    // Reset again mid-run: register fields must return to zero and the filter link to pin control
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    acc(1'b0, afe_power_hpf_pkg::FILTER_SW_ADDR, 32'h0, 32'h0, 1'b0);
    acc(1'b0, afe_power_hpf_pkg::LOW_POWER_ADDR, 32'h0, 32'h0, 1'b0);
    acc(1'b0, afe_power_hpf_pkg::MID_POWER_ADDR, 32'h0, 32'h0, 1'b0);
    chk(power_level, lvl(1'b0, 1'b0, cw), "level after reset");
    chk(filter_connect, conn(5'h00, pins), "pins after second reset");
    tally_and_finish();
  end
endmodule

`default_nettype wire
